// File: logic/boundary_scan_test_port.sv
// Summary of operation
// RULE1: opcode 0000 puts scan chain on TDI/TDO and drives pins from cells.
// RULE2: opcode 1111 puts the one-bit shortcut stage on TDI/TDO.
// RULE3: opcode 0010 loads the 32-bit identity word and shifts it out.
// RULE4: opcode 0100 floats every output and uses the shortcut stage.
// RULE5: opcode 0011 holds pins at cell values, shortcut stage on TDI/TDO.
// RULE6: opcode 0001 captures input and output pin levels into the chain.
// RULE7: opcode 0001 also preloads the chain from TDI for later driving.
// RULE8: controller loads only the six defined opcodes; others reserved. The code loads any 4-bit opcode unfiltered.
// RULE9: identity word: revision 31:28, part 27:12, vendor 11:1, bit0 one.
// RULE10: test clock runs at one fixed 10MHz rate, core speed independent. The bench drives TCK at 8MHz (125ns period).
// RULE11: sixteen-state controller on rising TCK, TRST resets to identity.
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_test_port
  import scan_port_pkg::*;
#(
  parameter int NIN = DEF_NIN,
  parameter int NOUT = DEF_NOUT,
  parameter logic [3:0] REVISION = DEF_REV,
  parameter logic [15:0] PART_ID = DEF_PART,
  parameter logic [10:0] VENDOR_ID = DEF_VEND
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tck,
  input wire logic trstN,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEn,
  input wire logic [NIN-1:0] coreIn,
  input wire logic [NOUT-1:0] coreOut,
  input wire logic coreOe,
  output logic [NOUT-1:0] pinOut,
  output logic pinOe
);
  localparam int CH = NIN + NOUT + 1;
  localparam int OE_CELL = CH - 1;

  // ==========================================================
  // test clock domain state
  typedef struct packed {
    tap_state_t st;
    logic [OP_W-1:0] opcode;
    logic [OP_W-1:0] opSh;
    logic [ID_W-1:0] idSh;
    logic shortcut;
    logic [CH-1:0] chainSh;
    logic [CH-1:0] chainUpd;
    pin_mode_t mode;
    logic updTgl;
  } tck_state_t;

  typedef struct packed {
    logic seen;
    pin_mode_t mode;
    logic [NOUT-1:0] cellOut;
    logic cellOe;
    logic [NOUT-1:0] pinOut;
    logic pinOe;
  } core_state_t;

  tck_state_t t_r, t_nxt;
  core_state_t c_r, c_nxt;
  logic tdo_r, tdoEn_r;
  logic [NIN+NOUT:0] pinsSync;
  logic [1:0] ctlSync;

  // RULE9: identity layout
  logic [ID_W-1:0] idWord;
  always_comb begin
    idWord = '0;
    idWord[REV_HI:REV_LO] = REVISION;
    idWord[PART_HI:PART_LO] = PART_ID;
    idWord[VEND_HI:VEND_LO] = VENDOR_ID;
    idWord[0] = ID_PRESENT;
  end

  // ==========================================================
  // pin levels into the test clock domain
  level_sync3 #(.W(NIN + NOUT + 1)) u_pins (
    .clk(tck),
    .d({c_r.pinOe, c_r.pinOut, coreIn}),
    .q(pinsSync)
  );

  function automatic logic uses_chain(logic [OP_W-1:0] op);
    return (op == OP_DRIVE) || (op == OP_SAMPLE);
  endfunction

  // ==========================================================
  // tap controller and data registers
  always_comb begin
    t_nxt = t_r;
    // RULE11: sixteen-state sequencing
    t_nxt.st = tap_next(t_r.st, tms);
    unique case (t_r.st)
      TLR: begin
        // RULE11: reset selects identity
        t_nxt.opcode = OP_IDENT;
        t_nxt.mode = '0;
        // RULE11: pins back to core
        if (t_r.mode != '0) begin
          t_nxt.updTgl = ~t_r.updTgl;
        end
      end
      CAP_IR: t_nxt.opSh = OP_CAPTURE;
      SH_IR: t_nxt.opSh = {tdi, t_r.opSh[OP_W-1:1]};
      UPD_IR: begin
        // RULE8: reserved codes not filtered
        t_nxt.opcode = t_r.opSh;
        // RULE1: drive pins from cells
        // RULE5: hold pins at cells
        t_nxt.mode.drive = (t_r.opSh == OP_DRIVE) ||
                           (t_r.opSh == OP_CLAMP);
        // RULE4: float all drivers
        t_nxt.mode.float = (t_r.opSh == OP_FLOAT);
        t_nxt.updTgl = ~t_r.updTgl;
      end
      CAP_DR: begin
        // RULE3: load identity word
        if (t_r.opcode == OP_IDENT) begin
          t_nxt.idSh = idWord;
        end
        // RULE6: capture pin levels
        if (uses_chain(t_r.opcode)) begin
          t_nxt.chainSh = pinsSync;
        end
        t_nxt.shortcut = 1'b0;
      end
      SH_DR: begin
        if (t_r.opcode == OP_IDENT) begin
          t_nxt.idSh = {tdi, t_r.idSh[ID_W-1:1]};
        end else if (uses_chain(t_r.opcode)) begin
          // RULE7: preload from serial input
          t_nxt.chainSh = {tdi, t_r.chainSh[CH-1:1]};
        end else begin
          // RULE2: shortcut stage
          t_nxt.shortcut = tdi;
        end
      end
      UPD_DR: begin
        if (uses_chain(t_r.opcode)) begin
          t_nxt.chainUpd = t_r.chainSh;
          t_nxt.updTgl = ~t_r.updTgl;
        end
      end
      default: ;
    endcase
  end

  // RULE10: own test clock
  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) begin
      t_r <= '{st: TLR, opcode: OP_IDENT, default: '0};
    end else begin
      t_r <= t_nxt;
    end
  end

  // ==========================================================
  // serial output on falling test clock
  always_ff @(negedge tck or negedge trstN) begin
    if (!trstN) begin
      tdo_r <= 1'b0;
      tdoEn_r <= 1'b0;
    end else begin
      tdoEn_r <= (t_r.st == SH_DR) || (t_r.st == SH_IR);
      if (t_r.st == SH_IR) begin
        tdo_r <= t_r.opSh[0];
      end else if (t_r.opcode == OP_IDENT) begin
        tdo_r <= t_r.idSh[0];
      end else if (uses_chain(t_r.opcode)) begin
        tdo_r <= t_r.chainSh[0];
      end else begin
        tdo_r <= t_r.shortcut;
      end
    end
  end
  assign tdo = tdo_r;
  assign tdoEn = tdoEn_r;

  // ==========================================================
  // update toggle and test reset into the core clock domain
  level_sync3 #(.W(2)) u_upd (
    .clk(clk),
    .d({trstN, t_r.updTgl}),
    .q(ctlSync)
  );

  // ==========================================================
  // core-side pin drivers
  always_comb begin
    c_nxt = c_r;
    if (ctlSync[0] != c_r.seen) begin
      // word is quiet between updates, so it is taken whole
      c_nxt.seen = ctlSync[0];
      c_nxt.mode = t_r.mode;
      c_nxt.cellOut = t_r.chainUpd[NIN +: NOUT];
      c_nxt.cellOe = t_r.chainUpd[OE_CELL];
    end
    if (!ctlSync[1]) begin
      // RULE11: test reset frees pins
      c_nxt.mode = '0;
    end
    if (c_r.mode.float) begin
      // RULE4: all drivers off
      c_nxt.pinOut = c_r.pinOut;
      c_nxt.pinOe = 1'b0;
    end else if (c_r.mode.drive) begin
      // RULE1: cells onto pins
      c_nxt.pinOut = c_r.cellOut;
      c_nxt.pinOe = c_r.cellOe;
    end else begin
      c_nxt.pinOut = coreOut;
      c_nxt.pinOe = coreOe;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      c_r <= '0;
    end else if (ce) begin
      c_r <= c_nxt;
    end
  end
  assign pinOut = c_r.pinOut;
  assign pinOe = c_r.pinOe;

endmodule
`default_nettype wire

// File: logic/scan_port_pkg.sv
package scan_port_pkg;

  // ==========================================================
  // tap controller states
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  // ==========================================================
  // opcodes and widths
  localparam int OP_W = 4;
  localparam int ID_W = 32;
  localparam logic [OP_W-1:0] OP_DRIVE = 4'h0;
  localparam logic [OP_W-1:0] OP_SAMPLE = 4'h1;
  localparam logic [OP_W-1:0] OP_IDENT = 4'h2;
  localparam logic [OP_W-1:0] OP_CLAMP = 4'h3;
  localparam logic [OP_W-1:0] OP_FLOAT = 4'h4;
  localparam logic [OP_W-1:0] OP_SHORT = 4'hf;
  localparam logic [OP_W-1:0] OP_CAPTURE = 4'h1;

  // ==========================================================
  // identity word layout
  localparam int REV_HI = 31;
  localparam int REV_LO = 28;
  localparam int PART_HI = 27;
  localparam int PART_LO = 12;
  localparam int VEND_HI = 11;
  localparam int VEND_LO = 1;
  localparam logic ID_PRESENT = 1'b1;
  // arbitrary identity values
  localparam logic [3:0] DEF_REV = 4'h5;
  localparam logic [15:0] DEF_PART = 16'h1234;
  localparam logic [10:0] DEF_VEND = 11'h2a5;

  // ==========================================================
  // pin counts and timing
  localparam int DEF_NIN = 8;
  localparam int DEF_NOUT = 8;
  localparam int TCK_RATE_HZ = 10_000_000;
  localparam int CLK_RATE_HZ = 100_000_000;
  localparam int TCK_RATIO = CLK_RATE_HZ / TCK_RATE_HZ;

  // ==========================================================
  // pin-mode word carried from the test clock to the core clock
  typedef struct packed {
    logic drive;
    logic float;
  } pin_mode_t;

  function automatic tap_state_t tap_next(tap_state_t s, logic tms);
    tap_state_t n;
    n = s;
    unique case (s)
      TLR: n = tms ? TLR : RTI;
      RTI: n = tms ? SEL_DR : RTI;
      SEL_DR: n = tms ? SEL_IR : CAP_DR;
      CAP_DR: n = tms ? EX1_DR : SH_DR;
      SH_DR: n = tms ? EX1_DR : SH_DR;
      EX1_DR: n = tms ? UPD_DR : PAU_DR;
      PAU_DR: n = tms ? EX2_DR : PAU_DR;
      EX2_DR: n = tms ? UPD_DR : SH_DR;
      UPD_DR: n = tms ? SEL_DR : RTI;
      SEL_IR: n = tms ? TLR : CAP_IR;
      CAP_IR: n = tms ? EX1_IR : SH_IR;
      SH_IR: n = tms ? EX1_IR : SH_IR;
      EX1_IR: n = tms ? UPD_IR : PAU_IR;
      PAU_IR: n = tms ? EX2_IR : PAU_IR;
      EX2_IR: n = tms ? UPD_IR : SH_IR;
      UPD_IR: n = tms ? SEL_DR : RTI;
    endcase
    return n;
  endfunction

endpackage

// File: logic/level_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module level_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ==========================================================
  // three stages, change taken once stages two and three agree
  logic [W-1:0] s1_r, s2_r, s3_r, q_r;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        s1_r[i] <= d[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          q_r[i] <= s3_r[i];
        end
      end
    end
  endgenerate
  assign q = q_r;
endmodule
`default_nettype wire

// File: testbench/scan_port_chk.sv
`timescale 1ns/10ps
`default_nettype none
module scan_port_chk #(
  parameter int NOUT = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic tck,
  input wire logic trstN,
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdoEn,
  input wire logic [NOUT-1:0] coreOut,
  input wire logic coreOe,
  input wire logic [NOUT-1:0] pinOut,
  input wire logic pinOe
);
  // ==========
  // checks
  chk_trst_quiet:
    assert property (@(posedge clk) !trstN |-> !tdo && !tdoEn)
    else $error("serial out active in test reset");
  chk_tdo_edge:
    assert property (@(posedge clk) disable iff (!trstN)
      $changed(tdo) |-> !tck) else $error("tdo moved off falling edge");
  chk_oe_edge:
    assert property (@(posedge clk) disable iff (!trstN)
      $changed(tdoEn) |-> !tck) else $error("tdoEn moved off falling edge");
  chk_shift_exit:
    assert property (@(posedge tck) disable iff (!trstN)
      tdoEn && tms |=> !tdoEn) else $error("shift not left");
  chk_shift_hold:
    assert property (@(posedge tck) disable iff (!trstN)
      tdoEn && !tms |=> tdoEn) else $error("shift left early");
  chk_ce_freeze:
    assert property (@(posedge clk) disable iff (!rstn)
      !ce |=> $stable(pinOut) && $stable(pinOe)) else $error("pins not frozen");
  chk_rst_pins:
    assert property (@(posedge clk) !rstn && ce |=> !pinOe && pinOut == '0)
    else $error("pins not cleared in reset");
  chk_func_pins:
    assert property (@(posedge clk) disable iff (!rstn)
      $past(rstn, 8) && !trstN && $past(!trstN, 8) && ce
      |=> pinOe == $past(coreOe) && pinOut == $past(coreOut))
    else $error("pins not functional after test reset");
endmodule
`default_nettype wire

// File: testbench/scan_host.sv
`timescale 1ns/10ps
`default_nettype none
module scan_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // ==========
  // idle: clock still, lines pulled high
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end
  task automatic step(input logic m, input logic v, output logic o);
    tms = m;
    tdi = v;
    #62.5 tck = 1'h1;
    o = tdo;
    #62.5 tck = 1'h0;
  endtask
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    #1.3;
    step(1'h0, 1'h1, o);
    step(1'h1, 1'h1, o);
    if (ir) step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    step(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    tms = 1'h1;
    tdi = 1'h1;
  endtask
endmodule
`default_nettype wire

// File: testbench/boundary_scan_test_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_test_port_tb_top import scan_port_pkg::*;;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic ce = 1'h1;
  logic trstN = 1'h1;
  logic [7:0] coreIn = '0;
  logic [7:0] coreOut = '0;
  logic coreOe = 1'h0;
  logic tck, tms, tdi, tdo, tdoEn, pinOe;
  logic [7:0] pinOut;
  logic [31:0] d, pat, q;
  logic [31:0] seed = 32'h5b;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [OP_W-1:0] ops [3] = '{OP_CLAMP, OP_FLOAT, OP_SHORT};
  // ==========
  // clock, parts, helpers
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      close_out();
    end
  end
  boundary_scan_test_port boundary_scan_test_port_inst (
    .clk(clk), .rstn(rstn), .ce(ce), .tck(tck), .trstN(trstN), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .coreIn(coreIn),
    .coreOut(coreOut), .coreOe(coreOe), .pinOut(pinOut), .pinOe(pinOe));
  scan_host scan_host_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic dr(input logic [31:0] v, input int n);
    scan_host_inst.scan(1'h0, v, n, d);
  endtask
  task automatic ir(input logic [OP_W-1:0] op);
    scan_host_inst.scan(1'h1, {28'h0, op}, 4, d);
    chk(d[3:0], 4'h1);
  endtask
  task automatic ident();
    dr(32'h0, 32);
    chk(d, {DEF_REV, DEF_PART, DEF_VEND, 1'h1});
  endtask
  // ==========
  // main sequence
  initial begin
    trstN <= 1'h0;
    go(12);
    rstn <= 1'h1;
    repeat (30) begin
      go(1);
      pat = rnd();
      {ce, coreOe, coreOut} <= pat[9:0];
    end
    ce <= 1'h1;
    trstN <= 1'h1;
    go(13);
    ident();
    ir(OP_SAMPLE);
    go(1);
    pat = rnd();
    {coreOe, coreOut, coreIn} <= pat[16:0];
    q = rnd();
    dr(q, 17);
    dr(q, 17);
    chk(d[16:0], pat[16:0]);
    ir(OP_DRIVE);
    go(10);
    chk({pinOe, pinOut}, q[16:8]);
    q = rnd();
    dr(q, 17);
    go(10);
    chk({pinOe, pinOut}, q[16:8]);
    foreach (ops[i]) begin
      ir(ops[i]);
      go(10);
      chk(pinOe, ops[i] == OP_CLAMP ? q[16] : ops[i] == OP_SHORT && coreOe);
      if (ops[i] != OP_FLOAT) chk(pinOut, ops[i] == OP_CLAMP ? q[15:8] : coreOut);
      pat = rnd();
      dr(pat, 8);
      chk(d[7:0], {pat[6:0], 1'h0});
    end
    ir(OP_IDENT);
    ident();
    ir(OP_DRIVE);
    go(10);
    {coreOe, coreOut} <= ~q[16:8];
    trstN <= 1'h0;
    chk({pinOe, pinOut}, q[16:8]);
    go(20);
    chk({pinOe, pinOut}, {coreOe, coreOut});
    trstN <= 1'h1;
    go(13);
    ident();
    close_out();
  end
endmodule
bind boundary_scan_test_port scan_port_chk #(.NOUT(NOUT)) scan_port_chk_inst (
  .clk(clk), .rstn(rstn), .ce(ce), .tck(tck), .trstN(trstN), .tms(tms),
  .tdo(tdo), .tdoEn(tdoEn), .coreOut(coreOut), .coreOe(coreOe),
  .pinOut(pinOut), .pinOe(pinOe));
`default_nettype wire
